// File: logic/adc_readout_pkg.sv
/*
 * Shared constants for the dual converter serial readout block.
 * Assumes a single system clock that oversamples the host serial clock.
 */
package adc_readout_pkg;
  localparam int RES_W = 14;
  localparam int WORD_W = 2 * RES_W;
  localparam int FIFO_DEPTH = 8;
  localparam int CTRL_W = 16;
  localparam int GAIN_W = 4;
  localparam int SHDN_W = 3;
  localparam int EDGE_W = 6;
  localparam logic [EDGE_W-1:0] POP_EDGE = 6'h12;
  localparam logic [EDGE_W-1:0] MSB_EDGE = 6'h13;
  localparam logic [EDGE_W-1:0] FRAME_EDGES = 6'h21;
  localparam logic [EDGE_W-1:0] EXTRA_EDGES = 6'h0E;
  localparam logic [EDGE_W-1:0] LAST_EDGE = FRAME_EDGES + EXTRA_EDGES - 6'h01;
  localparam logic [EDGE_W-1:0] EDGE_MAX = 6'h3F;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [7:0] CTRL_CNT_MAX = 8'hFF;
endpackage

// File: logic/dual_adc_serial_readout.sv
/*
 * Digital serial interface of a dual simultaneous-sampling 14-bit converter.
 * Assumes the serial pins are asynchronous to clk_sys_i and much slower than it.
 * Converter result pairs arrive on conv_data_i with a valid and ready handshake.
 */
`timescale 1ns/1ps
module dual_adc_serial_readout #(
  parameter int FIFO_DEPTH = adc_readout_pkg::FIFO_DEPTH,
  parameter int CTRL_W = adc_readout_pkg::CTRL_W
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic shutdown_sel0_or_ctrl_in_i,
  input wire logic shutdown_sel1_i,
  input wire logic shutdown_sel2_i,
  input wire logic gain_sel_bit0_i,
  input wire logic gain_sel_bit1_i,
  input wire logic gain_sel_bit2_i,
  input wire logic gain_sel_bit3_i,
  input wire logic conv_valid_i,
  input wire logic [adc_readout_pkg::WORD_W-1:0] conv_data_i,
  output logic conv_ready_o,
  output logic conv_start_o,
  output logic conv_tick_o,
  output logic result_out_a_o,
  output logic result_out_a_oe_o,
  output logic result_out_b_o,
  output logic result_out_b_oe_o,
  output logic [adc_readout_pkg::GAIN_W-1:0] gain_o,
  output logic [adc_readout_pkg::SHDN_W-1:0] shutdown_mode_o,
  output logic ctrl_mode_o,
  output logic [CTRL_W-1:0] ctrl_word_o,
  output logic ctrl_load_o
);
  import adc_readout_pkg::*;

  localparam int SYNC_W = 9;

  result_if #(.W(WORD_W)) rq ();

  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic sclk_d_r;
  logic cs_n_d_r;
  logic [EDGE_W-1:0] edge_cnt_r;
  logic [WORD_W-1:0] word_r;
  logic word_ok_r;
  logic dout_a_r;
  logic dout_b_r;
  logic oe_r;
  logic conv_start_r;
  logic conv_tick_r;
  logic [CTRL_W-1:0] ctrl_shift_r;
  logic [7:0] ctrl_bits_r;
  logic [CTRL_W-1:0] ctrl_word_r;
  logic ctrl_load_r;
  logic [GAIN_W-1:0] gain_r;
  logic [SHDN_W-1:0] shdn_r;

  wire sclk_s;
  wire cs_n_s;
  wire din_s;
  wire [SHDN_W-1:0] shdn_pins;
  wire [GAIN_W-1:0] gain_pins;
  wire sclk_fall;
  wire frame_on;
  wire frame_start;
  wire frame_end;
  wire ctrl_mode;
  wire [EDGE_W-1:0] edge_no;
  wire edge_in;
  wire [EDGE_W-1:0] bit_idx;
  wire [4:0] pick_a;
  wire [4:0] pick_b;
  wire [WORD_W-1:0] word_swap;
  wire pop_now;

  // Every serial, shutdown and gain pin passes two flip-flops before any logic looks at it; conv_valid_i and conv_data_i go straight to the FIFO.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_r <= {SYNC_W{1'b1}};
      sync2_r <= {SYNC_W{1'b1}};
    end else begin
      sync1_r <= {sclk_i, cs_n_i, shutdown_sel0_or_ctrl_in_i, shutdown_sel1_i,
                  shutdown_sel2_i, gain_sel_bit0_i, gain_sel_bit1_i,
                  gain_sel_bit2_i, gain_sel_bit3_i};
      sync2_r <= sync1_r;
    end
  end

  // Synchronised pin views and frame events.
  assign sclk_s = sync2_r[8];
  assign cs_n_s = sync2_r[7];
  assign din_s = sync2_r[6];
  assign shdn_pins = {sync2_r[4], sync2_r[5], sync2_r[6]};
  assign gain_pins = {sync2_r[0], sync2_r[1], sync2_r[2], sync2_r[3]};
  assign sclk_fall = sclk_d_r && !sclk_s;
  assign frame_on = !cs_n_s;
  assign frame_start = cs_n_d_r && !cs_n_s;
  assign frame_end = !cs_n_d_r && cs_n_s;
  assign ctrl_mode = (gain_pins == '0);
  assign edge_no = edge_cnt_r + 6'h01;
  assign edge_in = frame_on && sclk_fall;
  assign pop_now = edge_in && (edge_no == POP_EDGE);

  // Bit selection: edge 19 shows bit 27, the first channel's sign bit.
  assign bit_idx = edge_no - MSB_EDGE;
  assign pick_a = 5'(WORD_W - 1) - bit_idx[4:0];
  assign pick_b = pick_a;
  assign word_swap = {word_r[RES_W-1:0], word_r[WORD_W-1:RES_W]};

  // Result pairs wait in the FIFO; a full FIFO stalls the converter.
  assign rq.push_valid = conv_valid_i;
  assign rq.push_data = conv_data_i;
  assign rq.pop_ready = pop_now;
  assign conv_ready_o = rq.push_ready;

  result_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .q(rq)
  );

  // Falling-edge count inside a frame, cleared while chip select is high.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
      edge_cnt_r <= '0;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
      if (!frame_on) edge_cnt_r <= '0;
      else if (sclk_fall && edge_cnt_r != EDGE_MAX) edge_cnt_r <= edge_no;
    end
  end

  // Conversion start and a per-edge conversion step until the result is due.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      conv_start_r <= 1'b0;
      conv_tick_r <= 1'b0;
    end else begin
      conv_start_r <= frame_start;
      conv_tick_r <= edge_in && (edge_no < MSB_EDGE);
    end
  end

  // Result pair taken from the FIFO one edge before the sign bit is due.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_r <= '0;
      word_ok_r <= 1'b0;
    end else if (!frame_on) begin
      word_ok_r <= 1'b0;
    end else if (pop_now) begin
      word_r <= rq.pop_data;
      word_ok_r <= rq.pop_valid;
    end
  end

  // Serial outputs: released during conversion, driven from edge 19 on.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dout_a_r <= 1'b0;
      dout_b_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (!frame_on) begin
      oe_r <= 1'b0;
      dout_a_r <= 1'b0;
      dout_b_r <= 1'b0;
    end else if (edge_in && edge_no < MSB_EDGE) begin
      oe_r <= 1'b0;
    end else if (edge_in && edge_no <= LAST_EDGE) begin
      oe_r <= word_ok_r;
      dout_a_r <= word_r[pick_a];
      dout_b_r <= word_swap[pick_b];
    end else if (edge_in) begin
      dout_a_r <= 1'b0;
      dout_b_r <= 1'b0;
    end
  end

  // Control bits shift in on falling edges; the word loads at frame end.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_shift_r <= CTRL_RST;
      ctrl_bits_r <= '0;
      ctrl_word_r <= CTRL_RST;
      ctrl_load_r <= 1'b0;
    end else begin
      ctrl_load_r <= 1'b0;
      if (!frame_on) ctrl_bits_r <= '0;
      if (edge_in && ctrl_mode) begin
        ctrl_shift_r <= {ctrl_shift_r[CTRL_W-2:0], din_s};
        if (ctrl_bits_r != CTRL_CNT_MAX) ctrl_bits_r <= ctrl_bits_r + 8'h01;
      end
      if (frame_end && ctrl_mode && ctrl_bits_r >= 8'(CTRL_W)) begin
        ctrl_word_r <= ctrl_shift_r;
        ctrl_load_r <= 1'b1;
      end
    end
  end

  // Gain follows the pins or the control word; shutdown follows its pins, with bit 0 held low in control mode.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gain_r <= '0;
      shdn_r <= '0;
    end else begin
      gain_r <= ctrl_mode ? ctrl_word_r[GAIN_W-1:0] : gain_pins;
      shdn_r <= ctrl_mode ? {shdn_pins[2:1], 1'b0} : shdn_pins;
    end
  end

  assign conv_start_o = conv_start_r;
  assign conv_tick_o = conv_tick_r;
  assign result_out_a_o = dout_a_r;
  assign result_out_b_o = dout_b_r;
  assign result_out_a_oe_o = oe_r;
  assign result_out_b_oe_o = oe_r;
  assign gain_o = gain_r;
  assign shutdown_mode_o = shdn_r;
  assign ctrl_mode_o = ctrl_mode;
  assign ctrl_word_o = ctrl_word_r;
  assign ctrl_load_o = ctrl_load_r;
endmodule

// File: logic/result_fifo.sv
/*
 * Flip-flop FIFO for converter result words, valid and ready on both sides.
 * Assumes the system clock and the asynchronous active-low reset.
 */
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  result_if.fifo q
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Full mark at the counter's own width, so a power-of-two depth is not cut to zero.
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire do_push;
  wire do_pop;
  wire wr_wrap;
  wire rd_wrap;

  // Full and empty come straight from the occupancy count.
  assign q.push_ready = (count_r != DEPTH_C);
  assign q.pop_valid = (count_r != '0);
  assign q.pop_data = mem_r[rd_ptr_r];
  assign do_push = q.push_valid && q.push_ready;
  assign do_pop = q.pop_valid && q.pop_ready;
  assign wr_wrap = (wr_ptr_r == AW'(DEPTH - 1));
  assign rd_wrap = (rd_ptr_r == AW'(DEPTH - 1));

  // Storage is written only, never reset, to keep it plain flip-flops.
  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= q.push_data;
    end
  end

  // Pointers wrap at the depth; the count follows push minus pop.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_wrap ? '0 : wr_ptr_r + 1'b1;
      if (do_pop) rd_ptr_r <= rd_wrap ? '0 : rd_ptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// File: logic/result_if.sv
/*
 * Carrier for the result stream between the readout core and its FIFO.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ps
interface result_if #(
  parameter int W = 28
);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  modport fifo (input push_valid, input push_data, input pop_ready,
                output push_ready, output pop_valid, output pop_data);
  modport user (output push_valid, output push_data, output pop_ready,
                input push_ready, input pop_valid, input pop_data);
endinterface

// File: tb/dual_adc_serial_readout_tb.sv
/* Self-checking bench for the dual converter serial readout.
   Assumes the host port model, the bound checker and a 250 MHz system clock. */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module dual_adc_serial_readout_tb;
  import adc_readout_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic shutdown_sel1_i = 1'b1;
  logic shutdown_sel2_i = 1'b0;
  logic [3:0] gp = 4'h5;
  logic conv_valid_i = 1'b0;
  logic [WORD_W-1:0] conv_data_i = 28'h0000000;
  logic sclk_i, cs_n_i, shutdown_sel0_or_ctrl_in_i, conv_ready_o, conv_start_o, conv_tick_o;
  logic result_out_a_o, result_out_a_oe_o, result_out_b_o, result_out_b_oe_o;
  logic ctrl_mode_o, ctrl_load_o;
  logic [GAIN_W-1:0] gain_o;
  logic [SHDN_W-1:0] shutdown_mode_o;
  logic [CTRL_W-1:0] ctrl_word_o;
  int n_fail = 0;
  int n_compared = 0;
  int oe_cycles = 0;
  bit timed_out = 1'b0;
  dual_adc_serial_readout uut (.clk_sys_i, .rstn_i, .sclk_i, .cs_n_i,
    .shutdown_sel0_or_ctrl_in_i, .shutdown_sel1_i, .shutdown_sel2_i,
    .gain_sel_bit0_i(gp[0]), .gain_sel_bit1_i(gp[1]), .gain_sel_bit2_i(gp[2]),
    .gain_sel_bit3_i(gp[3]), .conv_valid_i, .conv_data_i, .conv_ready_o, .conv_start_o,
    .conv_tick_o, .result_out_a_o, .result_out_a_oe_o, .result_out_b_o, .result_out_b_oe_o,
    .gain_o, .shutdown_mode_o, .ctrl_mode_o, .ctrl_word_o, .ctrl_load_o);
  host_port_model hp (.clk_sys_i, .dout_a_i(result_out_a_o), .oe_a_i(result_out_a_oe_o),
    .dout_b_i(result_out_b_o), .oe_b_i(result_out_b_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i),
    .din_o(shutdown_sel0_or_ctrl_in_i));
  // Clock, and a count of cycles in which line A is driven.
  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    oe_cycles <= oe_cycles + int'(result_out_a_oe_o === 1'b1);
  end
  // Converter pair k: twos-complement codes k steps in from the extremes on both channels.
  function automatic logic [WORD_W-1:0] wd(input int k);
    return {14'h2000 + 14'(k), 14'h1FFF - 14'(k)};
  endfunction
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic t_pins;
    repeat (8) @(posedge clk_sys_i);
    `CHK(gain_o, 4'h5)
    `CHK(shutdown_mode_o, 3'h2)
    `CHK(ctrl_mode_o, 1'b0)
    $display("pins test done");
  endtask
  // Control word written with all gain pins low; the load pulse is awaited.
  task automatic t_ctrl;
    int i;
    gp <= 4'h0;
    repeat (8) @(posedge clk_sys_i);
    `CHK(ctrl_mode_o, 1'b1)
    hp.frame(16, 64'h000000000000A5C3);
    for (i = 0; i < 40 && ctrl_load_o !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    `CHK(i < 40, 1'b1)
    timed_out = (i == 40);
    repeat (2) @(posedge clk_sys_i);
    `CHK(ctrl_word_o, 16'hA5C3)
    `CHK(gain_o, 4'h3)
    `CHK(shutdown_mode_o, 3'h2)
    gp <= 4'h5;
    $display("control test done");
  endtask
  // Eight pairs back to back fill the buffer; a ninth is refused.
  task automatic t_fill;
    for (int k = 0; k < 8; k++) begin
      conv_valid_i <= 1'b1;
      conv_data_i <= wd(k);
      @(posedge clk_sys_i);
    end
    #1;
    `CHK(conv_ready_o, 1'b0)
    @(posedge clk_sys_i);
    conv_valid_i <= 1'b0;
    $display("fill test done");
  endtask
  // Chip select rises after edge 25, in mid-word.
  task automatic t_abort;
    logic [WORD_W-1:0] w;
    w = wd(0);
    hp.frame(25, 64'h0);
    repeat (8) @(posedge clk_sys_i);
    `CHK(result_out_a_oe_o, 1'b0)
    `CHK(hp.cap_a[6:0], w[27:21])
    `CHK(hp.cap_b[6:0], w[13:7])
    $display("abort test done");
  endtask
  // Full 47-edge frames drain the buffer, then one frame finds it empty.
  task automatic t_read;
    logic [WORD_W-1:0] w;
    int c0;
    for (int k = 1; k < 8; k++) begin
      w = wd(k);
      hp.frame(47, 64'h0);
      repeat (8) @(posedge clk_sys_i);
      `CHK(hp.cap_a[28:1], w)
      `CHK(hp.cap_b[28:1], {w[13:0], w[27:14]})
    end
    c0 = oe_cycles;
    hp.frame(47, 64'h0);
    `CHK(oe_cycles - c0, 0)
    `CHK(conv_ready_o, 1'b1)
    $display("read test done");
  endtask
  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_pins();
    t_ctrl();
    // A load that never came skips the rest and goes to the verdict.
    if (!timed_out) begin
      t_fill();
      @(posedge clk_sys_i);
      t_abort();
      t_read();
    end
    end_of_test();
  end
endmodule

// File: tb/host_port_model.sv
/* Behavioural host serial port that frames, clocks and captures both result lines.
   Assumes clk_sys_i as time base; the serial clock idles high outside frames. */
`timescale 1ns/1ps
module host_port_model (
  input wire logic clk_sys_i,
  input wire logic dout_a_i,
  input wire logic oe_a_i,
  input wire logic dout_b_i,
  input wire logic oe_b_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  logic last_a_r = 1'b0;
  logic last_b_r = 1'b0;
  logic [63:0] cap_a;
  logic [63:0] cap_b;
  // A released line toggles every cycle, so a stale bit can never pass.
  wire logic line_a = oe_a_i ? dout_a_i : ~last_a_r;
  wire logic line_b = oe_b_i ? dout_b_i : ~last_b_r;
  always @(posedge clk_sys_i) begin
    last_a_r <= line_a;
    last_b_r <= line_b;
  end
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // One frame of n falling edges at 32 ns; each bit is taken just before the next fall.
  task automatic frame(input int n, input logic [63:0] din_w);
    cs_n_o <= 1'b0;
    din_o <= din_w[n-1];
    for (int i = 1; i <= n; i++) begin
      repeat (4) @(posedge clk_sys_i);
      if (i > 1) begin
        cap_a <= {cap_a[62:0], line_a};
        cap_b <= {cap_b[62:0], line_b};
      end
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      if (i < n) begin
        din_o <= din_w[n-1-i];
      end
    end
    repeat (4) @(posedge clk_sys_i);
    cap_a <= {cap_a[62:0], line_a};
    cap_b <= {cap_b[62:0], line_b};
    cs_n_o <= 1'b1;
  endtask
endmodule

// File: tb/readout_properties.sv
/* Port checks for the dual converter serial readout.
   Assumes the bind below and a host serial clock much slower than clk_sys_i. */
`timescale 1ns/1ps
module readout_properties (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic shutdown_sel0_or_ctrl_in_i,
  input wire logic shutdown_sel1_i,
  input wire logic shutdown_sel2_i,
  input wire logic gain_sel_bit0_i,
  input wire logic gain_sel_bit1_i,
  input wire logic gain_sel_bit2_i,
  input wire logic gain_sel_bit3_i,
  input wire logic conv_start_o,
  input wire logic conv_tick_o,
  input wire logic result_out_a_o,
  input wire logic result_out_a_oe_o,
  input wire logic result_out_b_oe_o,
  input wire logic [adc_readout_pkg::GAIN_W-1:0] gain_o,
  input wire logic [adc_readout_pkg::SHDN_W-1:0] shutdown_mode_o
);
  import adc_readout_pkg::*;
  // Pins gathered as words, and conversion ticks counted since the frame began.
  wire logic [GAIN_W-1:0] gp = {gain_sel_bit3_i, gain_sel_bit2_i,
                                gain_sel_bit1_i, gain_sel_bit0_i};
  wire logic [SHDN_W-1:0] sp = {shutdown_sel2_i, shutdown_sel1_i, shutdown_sel0_or_ctrl_in_i};
  logic [4:0] ticks_r;
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ticks_r <= 5'h00;
    end else if (conv_start_o) begin
      ticks_r <= 5'h00;
    end else if (conv_tick_o) begin
      ticks_r <= ticks_r + 5'h01;
    end
  end
  // All checks share the system clock and its reset.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  oe_idle_a: assert property (cs_n_i [*8] |-> !result_out_a_oe_o && !result_out_b_oe_o)
    else $error("result line driven while deselected");
  msb_edge_a: assert property ($rose(result_out_a_oe_o) |-> ticks_r == 5'h12)
    else $error("result drive began at the wrong serial edge");
  conv_quiet_a: assert property (conv_tick_o |-> !result_out_a_oe_o && !result_out_b_oe_o)
    else $error("result line driven during conversion");
  lane_pair_a: assert property (result_out_a_oe_o == result_out_b_oe_o)
    else $error("result lines not driven together");
  shift_fall_a: assert property (
    result_out_a_oe_o && $past(result_out_a_oe_o) && $changed(result_out_a_o)
    |-> $past(sclk_i, 2) == 1'b0) else $error("result bit moved without a falling edge");
  start_cs_a: assert property (conv_start_o |-> !cs_n_i ##1 !conv_start_o)
    else $error("conversion start without chip select");
  gain_pins_a: assert property ((gp != 4'h0 && $stable(gp)) [*6] |-> gain_o == gp)
    else $error("gain does not follow its pins");
  shdn_pins_a: assert property ((gp != 4'h0 && $stable(sp)) [*6] |-> shutdown_mode_o == sp)
    else $error("shutdown mode does not follow its pins");
  // Main scenarios reached.
  cover property ($rose(result_out_a_oe_o));
  cover property (conv_start_o ##[1:20] conv_tick_o);
  cover property (gp == 4'h0);
endmodule
bind dual_adc_serial_readout readout_properties u_props (.clk_sys_i, .rstn_i, .sclk_i, .cs_n_i,
  .shutdown_sel0_or_ctrl_in_i, .shutdown_sel1_i, .shutdown_sel2_i, .gain_sel_bit0_i,
  .gain_sel_bit1_i, .gain_sel_bit2_i, .gain_sel_bit3_i, .conv_start_o, .conv_tick_o,
  .result_out_a_o, .result_out_a_oe_o, .result_out_b_oe_o, .gain_o, .shutdown_mode_o);
